//--- verilog/fbas_pkg.sv
/*
  fbas_pkg: constants, enumerations and carrier types of the four-bit
  datapath slice, with the map of its AHB-Lite register window.
  Assumes: included in compile order before fbas_slice.sv.
*/
`default_nettype none

package fbas_pkg;

  // ----------------------------------------------------------------
  // datapath sizes
  // ----------------------------------------------------------------
  localparam int WIDTH = 4;
  localparam int WORDS = 16;
  localparam int ADDR_W = 4;

  // ----------------------------------------------------------------
  // operand source codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_AQ = 3'b000,
    SRC_AB = 3'b001,
    SRC_ZQ = 3'b010,
    SRC_ZB = 3'b011,
    SRC_ZA = 3'b100,
    SRC_DA = 3'b101,
    SRC_DQ = 3'b110,
    SRC_DZ = 3'b111
  } fbas_src_type;

  // ----------------------------------------------------------------
  // function codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FN_ADD = 3'b000,
    FN_SUBR = 3'b001,
    FN_SUBS = 3'b010,
    FN_OR = 3'b011,
    FN_AND = 3'b100,
    FN_NOTRS = 3'b101,
    FN_XOR = 3'b110,
    FN_XNOR = 3'b111
  } fbas_func_type;

  // ----------------------------------------------------------------
  // destination codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DST_QREG = 3'b000,
    DST_NOP = 3'b001,
    DST_RAMA = 3'b010,
    DST_RAMF = 3'b011,
    DST_RAMQD = 3'b100,
    DST_RAMD = 3'b101,
    DST_RAMQU = 3'b110,
    DST_RAMU = 3'b111
  } fbas_dest_type;

  // nine-bit microinstruction: destination, function, source
  typedef struct packed {
    fbas_dest_type dest;
    fbas_func_type func;
    fbas_src_type src;
  } fbas_micro_type;

  // flag outputs of one slice
  typedef struct packed {
    logic carry_out;
    logic overflow_flag;
    logic sign_result_bit;
    logic zero_flag;
    logic generate_n;
    logic propagate_n;
  } fbas_flags_type;

  // ----------------------------------------------------------------
  // register window
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STATUS_Q_LSB = 0;
  localparam int STATUS_ZERO_BIT = 4;
  localparam int STATUS_SIGN_BIT = 5;
  localparam int STATUS_OVF_BIT = 6;
  localparam int STATUS_COUT_BIT = 7;
  localparam logic [3:0] Q_RESET = 4'h0;
  localparam logic [3:0] RAM_RESET = 4'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage : fbas_pkg

`default_nettype wire

//--- verilog/fbas_slice.sv
/*
  fbas_slice: one cascadable four-bit datapath slice with its register
  file, operand selectors, eight-function ALU, Q register, shifters,
  flag outputs and a small AHB-Lite control/status window.
  Assumes: microinstruction, addresses, carry and shift-port inputs come
  from logic on hclk; two-way pins are resolved outside from the enables.
*/
// How it works
// - sixteen four-bit words, two simultaneous read ports
// - equal addresses give same word on both ports
// - writes go only to the B-addressed word
// - write data: F plain, shifted up, or down
// - read operands held stable across the write
// - three arithmetic and five logic operations
// - R from A/D, S from A/B/Q, zero inhibit
// - source code selects eight operand pairs
// - direct data input loads registers, feeds ALU
// - separate four-bit Q register, source and destination
// - function code selects the ALU operation
// - active-low generate and propagate for look-ahead
// - active-high carry in and carry out
// - sign bit output regardless of Y enable
// - zero output high when F all low
// - overflow when carry into and out of msb differ
// - destination code routes F to Y/RAM/Q
// - Y three-state, released while enable pin high
// - all internal paths four bits wide
// - source decode table zero through seven
// - function decode table zero through seven
// - destination decode table zero through seven
// - Q and RAM both load at the same rising edge
`timescale 1ns/1ns
`default_nettype none

module fbas_slice (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // microinstruction and operand inputs
  input wire fbas_pkg::fbas_micro_type micro,
  input wire logic [3:0] a_address,
  input wire logic [3:0] b_address,
  input wire logic [3:0] direct_data,
  input wire logic carry_in,
  input wire logic y_enable_n,
  // data output (three-state)
  output logic [3:0] y_out,
  output logic y_oe_n,
  // register-file shift end ports
  input wire logic ram_lsb_in,
  output logic ram_lsb_out,
  output logic ram_lsb_oe_n,
  input wire logic ram_msb_in,
  output logic ram_msb_out,
  output logic ram_msb_oe_n,
  // Q shift end ports
  input wire logic q_lsb_in,
  output logic q_lsb_out,
  output logic q_lsb_oe_n,
  input wire logic q_msb_in,
  output logic q_msb_out,
  output logic q_msb_oe_n,
  // flags
  output fbas_pkg::fbas_flags_type flags,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // shift one word up (toward msb) or down, filling the vacated end
  function automatic logic [3:0] fbas_shift(input logic [3:0] word, input logic up, input logic fill);
    fbas_shift = up ? {word[2:0], fill} : {fill, word[3:1]};
  endfunction : fbas_shift

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [3:0] ram [0:15];
  logic [3:0] q_reg;
  logic [31:0] ctrl;
  logic hold;

  // ----------------------------------------------------------------
  // register-file read ports
  // ----------------------------------------------------------------
  // reads are combinational from the array, which only changes at the
  // rising edge, so both operands stay fixed for the whole cycle and a
  // write can never race its own operands
  logic [3:0] port_a;
  logic [3:0] port_b;
  assign port_a = ram[a_address];
  assign port_b = ram[b_address];

  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  // r from A or D, s from A, B or Q, each can be inhibited to zero
  logic r_from_a;
  logic r_zero;
  logic s_from_a;
  logic s_from_b;
  logic s_zero;
  logic [3:0] op_r;
  logic [3:0] op_s;
  assign r_from_a = (micro.src == fbas_pkg::SRC_AQ) || (micro.src == fbas_pkg::SRC_AB);
  assign r_zero = (micro.src == fbas_pkg::SRC_ZQ) || (micro.src == fbas_pkg::SRC_ZB)
                  || (micro.src == fbas_pkg::SRC_ZA);
  assign s_from_a = (micro.src == fbas_pkg::SRC_ZA) || (micro.src == fbas_pkg::SRC_DA);
  assign s_from_b = (micro.src == fbas_pkg::SRC_AB) || (micro.src == fbas_pkg::SRC_ZB);
  assign s_zero = (micro.src == fbas_pkg::SRC_DZ);
  assign op_r = r_zero ? 4'h0 : (r_from_a ? port_a : direct_data);
  assign op_s = s_zero ? 4'h0 : (s_from_a ? port_a : (s_from_b ? port_b : q_reg));

  // ----------------------------------------------------------------
  // ALU
  // ----------------------------------------------------------------
  // subtraction is an add of the complemented operand plus carry_in
  logic [3:0] add_r;
  logic [3:0] add_s;
  logic [3:0] gen;
  logic [3:0] prop;
  logic [4:0] carry;
  logic [3:0] sum;
  logic [3:0] alu_f;
  assign add_r = (micro.func == fbas_pkg::FN_SUBR) ? ~op_r : op_r;
  assign add_s = (micro.func == fbas_pkg::FN_SUBS) ? ~op_s : op_s;
  assign gen = add_r & add_s;
  assign prop = add_r | add_s;
  assign carry[0] = carry_in;
  assign carry[1] = gen[0] | (prop[0] & carry[0]);
  assign carry[2] = gen[1] | (prop[1] & carry[1]);
  assign carry[3] = gen[2] | (prop[2] & carry[2]);
  assign carry[4] = gen[3] | (prop[3] & carry[3]);
  assign sum = add_r ^ add_s ^ carry[3:0];

  // function decode
  always_comb begin
    case (micro.func)
      fbas_pkg::FN_ADD: alu_f = sum;
      fbas_pkg::FN_SUBR: alu_f = sum;
      fbas_pkg::FN_SUBS: alu_f = sum;
      fbas_pkg::FN_OR: alu_f = op_r | op_s;
      fbas_pkg::FN_AND: alu_f = op_r & op_s;
      fbas_pkg::FN_NOTRS: alu_f = ~op_r & op_s;
      fbas_pkg::FN_XOR: alu_f = op_r ^ op_s;
      fbas_pkg::FN_XNOR: alu_f = ~(op_r ^ op_s);
      default: alu_f = sum;
    endcase
  end

  // ----------------------------------------------------------------
  // flags
  // ----------------------------------------------------------------
  logic carry_into_msb;
  assign carry_into_msb = carry[3];
  assign flags.generate_n = ~(gen[3] | (prop[3] & gen[2]) | (&prop[3:2] & gen[1])
                              | (&prop[3:1] & gen[0]));
  assign flags.propagate_n = ~(&prop);
  assign flags.carry_out = carry[4];
  assign flags.sign_result_bit = alu_f[3];
  assign flags.zero_flag = (alu_f == 4'h0);
  assign flags.overflow_flag = carry_into_msb ^ carry[4];

  // ----------------------------------------------------------------
  // destination decode
  // ----------------------------------------------------------------
  logic ram_load;
  logic q_load;
  logic shift_on;
  logic shift_up;
  logic q_shift;
  assign ram_load = micro.dest[2] | micro.dest[1];
  assign q_load = (micro.dest == fbas_pkg::DST_QREG) || (micro.dest == fbas_pkg::DST_RAMQD)
                  || (micro.dest == fbas_pkg::DST_RAMQU);
  assign shift_on = micro.dest[2];
  assign shift_up = micro.dest[1];
  assign q_shift = shift_on & ~micro.dest[0];

  // three-way selectors into the register file and the Q register
  logic [3:0] ram_wdata;
  logic [3:0] next_q;
  assign ram_wdata = shift_on ? fbas_shift(alu_f, shift_up, shift_up ? ram_lsb_in : ram_msb_in)
                     : alu_f;
  assign next_q = q_shift ? fbas_shift(q_reg, shift_up, shift_up ? q_lsb_in : q_msb_in)
                  : alu_f;

  // ----------------------------------------------------------------
  // end ports: drive outgoing bit, release otherwise
  // ----------------------------------------------------------------
  assign ram_msb_out = alu_f[3];
  assign ram_msb_oe_n = ~(shift_on & shift_up);
  assign ram_lsb_out = alu_f[0];
  assign ram_lsb_oe_n = ~(shift_on & ~shift_up);
  assign q_msb_out = q_reg[3];
  assign q_msb_oe_n = ~(shift_on & shift_up);
  assign q_lsb_out = q_reg[0];
  assign q_lsb_oe_n = ~(shift_on & ~shift_up);

  // ----------------------------------------------------------------
  // Y output
  // ----------------------------------------------------------------
  assign y_out = (micro.dest == fbas_pkg::DST_RAMA) ? port_a : alu_f;
  assign y_oe_n = y_enable_n;

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  logic step;
  assign hold = ctrl[fbas_pkg::CTRL_HOLD_BIT];
  assign step = clk_en & ~hold;

  // Q register loads at the rising edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_reg <= fbas_pkg::Q_RESET;
    end else if (step && q_load) begin
      q_reg <= next_q;
    end
  end

  // register file writes only the B word, at the same edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < fbas_pkg::WORDS; i++) begin
        ram[i] <= fbas_pkg::RAM_RESET;
      end
    end else if (step && ram_load) begin
      ram[b_address] <= ram_wdata;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic take;
  logic dp_write;
  logic [31:0] dp_addr;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  assign take = hsel & hready & (htrans == fbas_pkg::HTRANS_NONSEQ) & (hsize == 3'h2); // whole words only
  assign status_word = {24'h00_0000, flags.carry_out, flags.overflow_flag,
                        flags.sign_result_bit, flags.zero_flag, q_reg};
  assign next_rdata = (haddr == fbas_pkg::CTRL_OFFSET) ? ctrl
                      : ((haddr == fbas_pkg::STATUS_OFFSET) ? status_word : 32'h0000_0000);
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always OKAY

  // address phase capture and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      dp_write <= take & hwrite;
      dp_addr <= haddr;
      if (take && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  // control register write in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= fbas_pkg::CTRL_RESET;
    end else if (dp_write && dp_addr == fbas_pkg::CTRL_OFFSET) begin
      ctrl <= {31'h0000_0000, hwdata[fbas_pkg::CTRL_HOLD_BIT]};
    end
  end

endmodule : fbas_slice

`default_nettype wire

//--- verification/fbas_slice_asserts.sv
/*
  fbas_slice_asserts: port checks of the datapath slice.
  Assumes: bound to fbas_slice; one clock, hresetn async active low.
*/
`timescale 1ns/1ns
`default_nettype none

module fbas_slice_asserts (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // datapath control
  input wire logic clk_en,
  input wire fbas_pkg::fbas_micro_type micro,
  input wire logic y_enable_n,
  // datapath results
  input wire logic [3:0] y_out,
  input wire logic y_oe_n,
  input wire fbas_pkg::fbas_flags_type flags,
  // shift end ports
  input wire logic ram_lsb_out,
  input wire logic ram_lsb_oe_n,
  input wire logic ram_msb_out,
  input wire logic ram_msb_oe_n,
  input wire logic q_lsb_in,
  input wire logic q_msb_in,
  input wire logic q_lsb_out,
  input wire logic q_msb_out,
  input wire logic q_lsb_oe_n,
  input wire logic q_msb_oe_n,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic ctrl_wr;
  logic hold;
  wire logic [2:0] dst = micro.dest;
  wire logic en = clk_en && !hold;

  // shadow of the hold bit, written in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_wr <= 1'b0;
      hold <= 1'b0;
    end else begin
      ctrl_wr <= hsel && hreadyout && htrans == fbas_pkg::HTRANS_NONSEQ && hwrite
        && haddr == fbas_pkg::CTRL_OFFSET;
      if (ctrl_wr) hold <= hwdata[fbas_pkg::CTRL_HOLD_BIT];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_y_release: assert property (y_oe_n == y_enable_n) else $error("y enable not followed");
  chk_zero_detect: assert property (dst != 3'h2 |-> flags.zero_flag == (y_out == 4'h0))
    else $error("zero flag wrong");
  chk_sign_out: assert property (dst != 3'h2 |-> flags.sign_result_bit == y_out[3])
    else $error("sign bit wrong");
  chk_down_port: assert property (dst[2:1] == 2'h2
    |-> !ram_lsb_oe_n && ram_msb_oe_n && !q_lsb_oe_n && q_msb_oe_n && ram_lsb_out == y_out[0])
    else $error("down shift port wrong");
  chk_up_port: assert property (dst[2:1] == 2'h3
    |-> !ram_msb_oe_n && ram_lsb_oe_n && !q_msb_oe_n && q_lsb_oe_n && ram_msb_out == y_out[3])
    else $error("up shift port wrong");
  chk_no_shift: assert property (!dst[2] |-> ram_lsb_oe_n && ram_msb_oe_n && q_lsb_oe_n && q_msb_oe_n)
    else $error("end port driven");
  chk_q_load: assert property (en && dst == 3'h0
    |=> {q_msb_out, q_lsb_out} == {$past(y_out[3]), $past(y_out[0])})
    else $error("q not loaded from f");
  chk_q_down: assert property (en && dst == 3'h4 |=> q_msb_out == $past(q_msb_in)) else $error("q down fill");
  chk_q_up: assert property (en && dst == 3'h6 |=> q_lsb_out == $past(q_lsb_in)) else $error("q up fill");
  chk_q_freeze: assert property (!en |=> $stable(q_lsb_out) && $stable(q_msb_out)) else $error("q moved");

  // main scenarios seen
  cov_q_down: cover property (en && dst == 3'h4);
  cov_y_off: cover property (y_enable_n && !flags.zero_flag);
  cov_hold: cover property (hold && clk_en);
endmodule : fbas_slice_asserts

`default_nettype wire

//--- verification/fbas_nbr.sv
/*
  fbas_nbr: neighbouring slices at the four shift end lines.
  Assumes: neighbour edge bits come from the bench as fill.
*/
`timescale 1ns/1ns
`default_nettype none

module fbas_nbr (
  // slice end buffers
  input wire logic ram_lsb_out,
  input wire logic ram_lsb_oe_n,
  input wire logic ram_msb_out,
  input wire logic ram_msb_oe_n,
  input wire logic q_lsb_out,
  input wire logic q_lsb_oe_n,
  input wire logic q_msb_out,
  input wire logic q_msb_oe_n,
  // neighbour bits: ram lsb, ram msb, q lsb, q msb
  input wire logic [3:0] fill,
  // resolved lines
  output logic ram_lsb_in,
  output logic ram_msb_in,
  output logic q_lsb_in,
  output logic q_msb_in
);
  // ----------------------------------------------------------------
  // line levels
  // ----------------------------------------------------------------
  // neighbour drives a line only while the slice has released it
  assign ram_lsb_in = ram_lsb_oe_n ? fill[0] : ram_lsb_out;
  assign ram_msb_in = ram_msb_oe_n ? fill[1] : ram_msb_out;
  assign q_lsb_in = q_lsb_oe_n ? fill[2] : q_lsb_out;
  assign q_msb_in = q_msb_oe_n ? fill[3] : q_msb_out;
endmodule : fbas_nbr

`default_nettype wire

//--- verification/tb_fbas_slice.sv
/*
  tb_fbas_slice: directed bench for the slice and its register window.
  Assumes: fbas_pkg, fbas_slice, fbas_nbr and the checker compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_fbas_slice;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1, y_enable_n = 1'b0, carry_in = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  fbas_pkg::fbas_micro_type micro = 9'h000;
  logic [3:0] a_address = 4'h0, b_address = 4'h0, direct_data = 4'h0, fill = 4'h9, y_out, r, sv;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic y_oe_n, ram_lsb_out, ram_lsb_oe_n, ram_msb_out, ram_msb_oe_n, q_lsb_out, q_lsb_oe_n, q_msb_out;
  logic q_msb_oe_n, ram_lsb_in, ram_msb_in, q_lsb_in, q_msb_in, hreadyout, hresp;
  logic [9:0] e;
  fbas_pkg::fbas_flags_type flags;
  wire logic hready = hreadyout;
  int mismatches = 0, comparisons = 0;

  fbas_slice uut (.hclk, .hresetn, .clk_en, .micro, .a_address, .b_address, .direct_data, .carry_in,
    .y_enable_n, .y_out, .y_oe_n, .ram_lsb_in, .ram_lsb_out, .ram_lsb_oe_n, .ram_msb_in, .ram_msb_out,
    .ram_msb_oe_n, .q_lsb_in, .q_lsb_out, .q_lsb_oe_n, .q_msb_in, .q_msb_out, .q_msb_oe_n, .flags, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp);
  fbas_nbr nbr (.ram_lsb_out, .ram_lsb_oe_n, .ram_msb_out, .ram_msb_oe_n, .q_lsb_out, .q_lsb_oe_n,
    .q_msb_out, .q_msb_oe_n, .fill, .ram_lsb_in, .ram_msb_in, .q_lsb_in, .q_msb_in);

  // 50 MHz clock
  always #10 hclk = ~hclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] rv(input int i);
    return 4'(i) ^ 4'h5;
  endfunction : rv

  // expected {carry, overflow, sign, zero, g_n, p_n, f}
  function automatic logic [9:0] ref_alu(input logic [3:0] r, s, input logic [2:0] fn, input logic c);
    logic [3:0] x, y, f;
    logic [4:0] sum;
    logic g;
    x = (fn == 3'h1) ? ~r : r;
    y = (fn == 3'h2) ? ~s : s;
    sum = x + y + c;
    g = 1'b0;
    for (int i = 0; i < 4; i++) g = (x[i] & y[i]) | ((x[i] | y[i]) & g);
    case (fn)
      3'h3: f = r | s;
      3'h4: f = r & s;
      3'h5: f = ~r & s;
      3'h6: f = r ^ s;
      3'h7: f = ~(r ^ s);
      default: f = sum[3:0];
    endcase
    return {sum[4], sum[4] ^ sum[3] ^ x[3] ^ y[3], f[3], f == 4'h0, ~g, ~&(x | y), f};
  endfunction : ref_alu

  task automatic check(input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one single AHB-Lite word transfer
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= fbas_pkg::HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    check(hresp, 1'b0);
  endtask : ahb

  // one microinstruction, outputs sampled mid-cycle
  task automatic op(input logic [2:0] s, fn, dst, input logic [3:0] a, b, d, input logic c, input logic en = 1'b1);
    @(posedge hclk);
    micro <= fbas_pkg::fbas_micro_type'({dst, fn, s});
    a_address <= a;
    b_address <= b;
    direct_data <= d;
    carry_in <= c;
    clk_en <= en;
    #10;
  endtask : op

  task automatic alu_check(input logic [3:0] r, s, input logic [2:0] fn, input logic c);
    e = ref_alu(r, s, fn, c);
    check(y_out, e[3:0]);
    check(flags, e[9:4]);
  endtask : alu_check

  // shifted store with given neighbour bits, then read back the B word and Q
  task automatic shift_case(input logic [2:0] dst, input logic [3:0] b, d, er, eq, input logic [3:0] nf = 4'h9);
    @(posedge hclk);
    fill <= nf;
    op(3'h7, 3'h0, dst, 4'h0, b, d, 1'b0);
    op(3'h3, 3'h3, 3'h1, 4'h0, b, 4'h0, 1'b0);
    check(y_out, er);
    op(3'h2, 3'h3, 3'h1, 4'h0, 4'h0, 4'h0, 1'b0);
    check(y_out, eq);
  endtask : shift_case

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, fbas_pkg::STATUS_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0010);
    ahb(1'b0, fbas_pkg::CTRL_OFFSET, 32'h0000_0000);
    check(rd, fbas_pkg::CTRL_RESET);
    ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    for (int i = 0; i < 16; i++) begin
      op(3'h7, 3'h0, 3'h3, 4'h0, 4'(i), rv(i), 1'b0);
      check(y_out, rv(i));
    end
    op(3'h7, 3'h0, 3'h0, 4'h0, 4'h0, 4'hb, 1'b0);
    op(3'h1, 3'h3, 3'h1, 4'h7, 4'h7, 4'h0, 1'b0);
    check(y_out, rv(7));
    for (int s = 0; s < 8; s++) begin
      op(3'(s), 3'h0, 3'h1, 4'h4, 4'h9, 4'h6, 1'b1);
      r = (s < 2) ? rv(4) : (s < 5) ? 4'h0 : 4'h6;
      sv = (s == 4 || s == 5) ? rv(4) : (s == 7) ? 4'h0 : s[0] ? rv(9) : 4'hb;
      alu_check(r, sv, 3'h0, 1'b1);
    end
    for (int n = 0; n < 32; n++) begin
      op(3'h1, n[2:0], 3'h1, n[4] ? 4'h2 : 4'h4, n[4] ? 4'h7 : 4'h9, 4'h0, n[3]);
      alu_check(rv(n[4] ? 2 : 4), rv(n[4] ? 7 : 9), n[2:0], n[3]);
    end
    op(3'h1, 3'h0, 3'h2, 4'h3, 4'he, 4'h0, 1'b0);
    check(y_out, rv(3));
    op(3'h1, 3'h6, 3'h1, 4'h3, 4'he, 4'h0, 1'b0);
    check(y_out, 4'h7);
    shift_case(3'h4, 4'h5, 4'h6, 4'hb, 4'h5, 4'h6);
    shift_case(3'h6, 4'h6, 4'h6, 4'hc, 4'hb, 4'h6);
    shift_case(3'h4, 4'h5, 4'h6, 4'h3, 4'hd);
    shift_case(3'h6, 4'h6, 4'h6, 4'hd, 4'ha);
    shift_case(3'h5, 4'h8, 4'h9, 4'h4, 4'ha);
    shift_case(3'h7, 4'ha, 4'h9, 4'h3, 4'ha);
    op(3'h7, 3'h0, 3'h0, 4'h0, 4'h0, 4'h3, 1'b0, 1'b0);
    op(3'h2, 3'h3, 3'h1, 4'h0, 4'h0, 4'h0, 1'b0);
    check(y_out, 4'ha);
    ahb(1'b1, fbas_pkg::CTRL_OFFSET, 32'h0000_0001);
    ahb(1'b0, fbas_pkg::CTRL_OFFSET, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    op(3'h7, 3'h0, 3'h0, 4'h0, 4'h0, 4'h3, 1'b0);
    op(3'h2, 3'h3, 3'h1, 4'h0, 4'h0, 4'h0, 1'b0);
    check(y_out, 4'ha);
    ahb(1'b1, fbas_pkg::CTRL_OFFSET, 32'h0000_0000);
    ahb(1'b0, fbas_pkg::STATUS_OFFSET, 32'h0000_0000);
    e = ref_alu(4'h0, 4'ha, 3'h3, 1'b0);
    check(rd, {24'h00_0000, e[9:6], 4'ha});
    @(posedge hclk);
    y_enable_n <= 1'b1;
    #10;
    check(y_oe_n, 1'b1);
    check(flags.sign_result_bit, 1'b1);
    @(posedge hclk);
    y_enable_n <= 1'b0;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    op(3'h3, 3'h3, 3'h1, 4'h0, 4'h6, 4'h0, 1'b0);
    check(y_out, 4'h0);
    check(y_oe_n, 1'b0);
    close_out();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge hclk);
    mismatches++;
    close_out();
  end
endmodule : tb_fbas_slice

bind fbas_slice fbas_slice_asserts chk (.hclk, .hresetn, .clk_en, .micro, .y_enable_n, .y_out, .y_oe_n,
  .flags, .ram_lsb_out, .ram_lsb_oe_n, .ram_msb_out, .ram_msb_oe_n, .q_lsb_in, .q_msb_in, .q_lsb_out,
  .q_msb_out, .q_lsb_oe_n, .q_msb_oe_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hreadyout);

`default_nettype wire
